// *** design/scp_pkg.sv ***
// Purpose: Shared constants and types for the capture/status parameter bank
// Assumes: 100 MHz reference clock, 16-bit parameter words
// Notes:   Parameter addresses are the fieldbus word addresses
package scp_pkg;

  // Word width of every parameter
  localparam int unsigned DATA_W = 16;
  typedef logic [DATA_W-1:0] scp_word_t;

  // Parameter addresses
  localparam scp_word_t ADDR_CAP_FLAGS   = 16'h0a02;
  localparam scp_word_t ADDR_EDGE_FLAGS  = 16'h0a3e;
  localparam scp_word_t ADDR_EVT_SUMMARY = 16'h0a5e;
  localparam scp_word_t ADDR_KP_D        = 16'h1102;
  localparam scp_word_t ADDR_KP_Q        = 16'h1106;
  localparam scp_word_t ADDR_ACT_SET     = 16'h112e;
  localparam scp_word_t ADDR_READY       = 16'h1c4c;

  // Field widths
  localparam int unsigned CAP_N  = 3;
  localparam int unsigned EDGE_N = 4;
  localparam int unsigned NIB_W  = 4;

  // Event counter summary nibble positions
  localparam int unsigned SUM_I1R_LSB = 0;
  localparam int unsigned SUM_I1F_LSB = 4;
  localparam int unsigned SUM_I2R_LSB = 8;
  localparam int unsigned SUM_I2F_LSB = 12;

  // Active controller set encodings, set 1 after reset
  localparam scp_word_t SET_ONE     = 16'h0001;
  localparam scp_word_t SET_TWO     = 16'h0002;
  localparam scp_word_t ACT_SET_RST = SET_ONE;

  // Proportional gain limits in 0.1 V/A steps (0.5 and 1270.0 V/A)
  localparam scp_word_t GAIN_MIN = 16'h0005;
  localparam scp_word_t GAIN_MAX = 16'h319c;
  localparam scp_word_t GAIN_RST = GAIN_MIN;

  // Set switching delay unit: 1 ms
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned DELAY_UNIT_NS     = 1000000;
  localparam int unsigned DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // Parameter access request from the fieldbus side
  typedef struct packed {
    logic      valid;
    logic      write;
    scp_word_t addr;
    scp_word_t wdata;
  } scp_req_s;

  // Parameter access answer
  typedef struct packed {
    logic      valid;
    logic      err;
    scp_word_t data;
  } scp_rsp_s;

  // Full-width capture event counters from the capture logic
  typedef struct packed {
    scp_word_t in2_fall;
    scp_word_t in2_rise;
    scp_word_t in1_fall;
    scp_word_t in1_rise;
  } scp_counts_s;

  // Readiness conditions, bit 0 in the last field
  typedef struct packed {
    logic brake_not_released;
    logic abs_pos_set;
    logic vel_over_limit;
    logic no_cfg_download;
    logic safety_inputs_ok;
    logic dc_bus_present;
  } scp_cond_s;

  // Set switching sequencer
  typedef enum logic {SW_IDLE, SW_WAIT} scp_sw_state_e;

endpackage

// *** design/scp_tick_div.sv ***
// Purpose: One-cycle enable pulse every P_CYCLES clocks
// Assumes: P_CYCLES is at least 1
// Notes:   Clearing restarts a whole period so a delay never ends early
`timescale 1ns/1ps
module scp_tick_div #(
  parameter int unsigned P_CYCLES = scp_pkg::DELAY_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_clear,
  // Enable pulse
  output logic      o_tick
);

  localparam int unsigned CW = $clog2(P_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

  logic [CW-1:0] cnt;

  // Period counter, held at zero while cleared
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_clear) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule

// *** design/scp_param_bank.sv ***
// Purpose: Read-only capture, readiness and current-loop parameter bank
// Assumes: Inputs synchronous to i_ref_clk; one request per cycle at most
// Notes:   Answer follows a request by one cycle; writes are refused
`timescale 1ns/1ps

// Contract
// R1: Summary bits 0-3 and 4-7 hold the input 1 rise and fall count nibbles.
// R2: Summary bits 8-11 and 12-15 hold the input 2 rise and fall nibbles.
// R3: The summary is a 16-bit unsigned read-only word.
// R4: Capture flag bits 0, 1, 2 show a capture on inputs one, two, three.
// R5: Each readiness bit reads 1 when its condition is met and 0 otherwise.
// R6: Readiness bits 0, 1, 2 are bus voltage, safety inputs, no download.
// R7: Readiness bits 3, 4, 5 are over-speed, position set, brake held.
// R8: The active set reads 1 for controller set 1 and 2 for controller set 2.
// R9: A new set is reported active only after the full switching delay.
// R10: The d-axis gain is 16-bit unsigned, 0.1 V/A steps, 0.5 to 1270.0 V/A.
// R11: The q-axis gain is 16-bit unsigned, 0.1 V/A steps, 0.5 to 1270.0 V/A.
// R12: A changed gain takes effect at once with no deferred step.
// R13: Edge flag bits 0-1 are input 1 rise/fall, bits 2-3 input 2 rise/fall.
// R14: Writes to any of these parameters are ignored and change nothing.
module scp_param_bank #(
  parameter int unsigned P_DELAY_UNIT_CYCLES = scp_pkg::DELAY_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  // Parameter access port
  input  wire scp_pkg::scp_req_s         i_req,
  output scp_pkg::scp_rsp_s              o_rsp,
  // Capture logic status
  input  wire logic [scp_pkg::CAP_N-1:0] i_cap_captured,
  input  wire logic [scp_pkg::EDGE_N-1:0] i_edge_seen,
  input  wire scp_pkg::scp_counts_s      i_counts,
  // Drive state conditions
  input  wire scp_pkg::scp_cond_s        i_ready_cond,
  // Controller set selection
  input  wire logic                      i_set_sel,
  input  wire scp_pkg::scp_word_t        i_set_switch_delay,
  output scp_pkg::scp_word_t             o_active_set,
  // Gains computed from motor parameters
  input  wire scp_pkg::scp_word_t        i_kp_d_calc,
  input  wire scp_pkg::scp_word_t        i_kp_q_calc,
  output scp_pkg::scp_word_t             o_kp_d,
  output scp_pkg::scp_word_t             o_kp_q
);

  // Address decode shared by the error path and the checks
  function automatic logic is_mapped(input scp_pkg::scp_word_t a);
    is_mapped = (a == scp_pkg::ADDR_CAP_FLAGS)   ||
                (a == scp_pkg::ADDR_EDGE_FLAGS)  ||
                (a == scp_pkg::ADDR_EVT_SUMMARY) ||
                (a == scp_pkg::ADDR_KP_D)        ||
                (a == scp_pkg::ADDR_KP_Q)        ||
                (a == scp_pkg::ADDR_ACT_SET)     ||
                (a == scp_pkg::ADDR_READY);
  endfunction

  // Gain limiting, same for both axes
  function automatic scp_pkg::scp_word_t clamp_gain(
    input scp_pkg::scp_word_t g
  );
    if (g < scp_pkg::GAIN_MIN) begin
      clamp_gain = scp_pkg::GAIN_MIN;
    end else if (g > scp_pkg::GAIN_MAX) begin
      clamp_gain = scp_pkg::GAIN_MAX;
    end else begin
      clamp_gain = g;
    end
  endfunction

  logic [scp_pkg::CAP_N-1:0]  cap_flags;
  logic [scp_pkg::EDGE_N-1:0] edge_flags;
  scp_pkg::scp_word_t         evt_summary;
  scp_pkg::scp_cond_s         ready;
  scp_pkg::scp_word_t         next_rd_data;
  scp_pkg::scp_word_t         target_set;
  scp_pkg::scp_word_t         pend_set;
  scp_pkg::scp_word_t         delay_lat;
  scp_pkg::scp_word_t         elapsed;
  scp_pkg::scp_word_t         next_elapsed;
  scp_pkg::scp_sw_state_e     sw_state;
  logic                       unit_tick;
  logic                       delay_done;

  // Status snapshots, refreshed every cycle from the capture logic
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cap_flags  <= '0;
      edge_flags <= '0;
    end else begin
      cap_flags  <= i_cap_captured;  // R4
      edge_flags <= i_edge_seen;     // R13
    end
  end

  // Counter summary: only the low nibble of each counter survives
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      evt_summary <= '0;
    end else begin
      evt_summary[scp_pkg::SUM_I1R_LSB +: scp_pkg::NIB_W] <=
        i_counts.in1_rise[scp_pkg::NIB_W-1:0];  // R1
      evt_summary[scp_pkg::SUM_I1F_LSB +: scp_pkg::NIB_W] <=
        i_counts.in1_fall[scp_pkg::NIB_W-1:0];  // R1
      evt_summary[scp_pkg::SUM_I2R_LSB +: scp_pkg::NIB_W] <=
        i_counts.in2_rise[scp_pkg::NIB_W-1:0];  // R2
      evt_summary[scp_pkg::SUM_I2F_LSB +: scp_pkg::NIB_W] <=
        i_counts.in2_fall[scp_pkg::NIB_W-1:0];  // R2
    end
  end

  // Readiness: struct order fixes the bit of each condition
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ready <= '0;
    end else begin
      ready <= i_ready_cond;  // R5 R6 R7
    end
  end

  // Gains pass straight through, limited to the legal range
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_kp_d <= scp_pkg::GAIN_RST;
      o_kp_q <= scp_pkg::GAIN_RST;
    end else begin
      o_kp_d <= clamp_gain(i_kp_d_calc);  // R10 R12
      o_kp_q <= clamp_gain(i_kp_q_calc);  // R11 R12
    end
  end

  // Set switching: delay counted in whole units from a fresh divider
  assign target_set   = i_set_sel ? scp_pkg::SET_TWO : scp_pkg::SET_ONE;
  assign next_elapsed = elapsed + 1'b1;
  assign delay_done   = unit_tick && (next_elapsed == delay_lat);

  // Divider is cleared outside a wait, so the first unit is whole
  scp_tick_div #(
    .P_CYCLES (P_DELAY_UNIT_CYCLES)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clear   (sw_state == scp_pkg::SW_IDLE),
    .o_tick    (unit_tick)
  );

  // Switching sequencer; a changed request aborts the wait
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sw_state     <= scp_pkg::SW_IDLE;
      o_active_set <= scp_pkg::ACT_SET_RST;  // R8
      pend_set     <= scp_pkg::ACT_SET_RST;
      delay_lat    <= '0;
      elapsed      <= '0;
    end else begin
      unique case (sw_state)
        scp_pkg::SW_IDLE: begin
          elapsed <= '0;
          if (target_set != o_active_set) begin
            if (i_set_switch_delay == '0) begin
              o_active_set <= target_set;  // R9
            end else begin
              sw_state  <= scp_pkg::SW_WAIT;
              pend_set  <= target_set;
              delay_lat <= i_set_switch_delay;
            end
          end
        end
        scp_pkg::SW_WAIT: begin
          if (target_set != pend_set) begin
            sw_state <= scp_pkg::SW_IDLE;
          end else if (delay_done) begin
            o_active_set <= pend_set;  // R9
            sw_state     <= scp_pkg::SW_IDLE;
          end else if (unit_tick) begin
            elapsed <= next_elapsed;
          end
        end
      endcase
    end
  end

  // Read mux over the snapshots; unmapped words read as zero
  always_comb begin
    next_rd_data = '0;
    case (i_req.addr)
      scp_pkg::ADDR_CAP_FLAGS:   next_rd_data =
        scp_pkg::scp_word_t'(cap_flags);   // R4
      scp_pkg::ADDR_EDGE_FLAGS:  next_rd_data =
        scp_pkg::scp_word_t'(edge_flags);  // R13
      scp_pkg::ADDR_EVT_SUMMARY: next_rd_data = evt_summary;  // R3
      scp_pkg::ADDR_KP_D:        next_rd_data = o_kp_d;
      scp_pkg::ADDR_KP_Q:        next_rd_data = o_kp_q;
      scp_pkg::ADDR_ACT_SET:     next_rd_data = o_active_set;
      scp_pkg::ADDR_READY:       next_rd_data =
        scp_pkg::scp_word_t'(ready);       // R5
      default:                   next_rd_data = '0;
    endcase
  end

  // Answer one cycle after each request; writes never reach storage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_req.valid;
      o_rsp.err   <= i_req.valid &&
                     (i_req.write || !is_mapped(i_req.addr));  // R14
      o_rsp.data  <= (i_req.valid && !i_req.write) ? next_rd_data : '0;
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  function automatic logic rd_at(input scp_pkg::scp_req_s r,
                                 input scp_pkg::scp_word_t a);
    rd_at = r.valid && !r.write && (r.addr == a);
  endfunction

  property p_sum_low;
    rd_at(i_req, scp_pkg::ADDR_EVT_SUMMARY) |=> o_rsp.valid &&
      o_rsp.data[7:0] == {$past(i_counts.in1_fall[3:0], 2),
                          $past(i_counts.in1_rise[3:0], 2)};
  endproperty
  a_sum_low: assert property (p_sum_low) else $error("summary low"); // R1

  property p_sum_high;
    rd_at(i_req, scp_pkg::ADDR_EVT_SUMMARY) |=>
      o_rsp.data[15:8] == {$past(i_counts.in2_fall[3:0], 2),
                           $past(i_counts.in2_rise[3:0], 2)};
  endproperty
  a_sum_high: assert property (p_sum_high) else $error("summary high"); // R2

  // A set switch may land during a write, so only a quiet sequencer counts
  property p_write_refused;
    (i_req.valid && i_req.write && sw_state == scp_pkg::SW_IDLE &&
     target_set == o_active_set) |=> o_rsp.valid && o_rsp.err &&
      o_rsp.data == '0 && $stable(o_active_set);
  endproperty
  a_write_refused: assert property (p_write_refused) // R14
    else $error("write not refused");

  property p_cap_flags;
    rd_at(i_req, scp_pkg::ADDR_CAP_FLAGS) |=> !o_rsp.err &&
      o_rsp.data == scp_pkg::scp_word_t'($past(i_cap_captured, 2));
  endproperty
  a_cap_flags: assert property (p_cap_flags) else $error("cap flags"); // R4

  property p_ready;
    rd_at(i_req, scp_pkg::ADDR_READY) |=>
      o_rsp.data == scp_pkg::scp_word_t'($past(i_ready_cond, 2));
  endproperty
  a_ready: assert property (p_ready) else $error("readiness word"); // R6

  property p_edge;
    rd_at(i_req, scp_pkg::ADDR_EDGE_FLAGS) |=>
      o_rsp.data == scp_pkg::scp_word_t'($past(i_edge_seen, 2));
  endproperty
  a_edge: assert property (p_edge) else $error("edge flags"); // R13

  property p_set_legal;
    o_active_set == scp_pkg::SET_ONE || o_active_set == scp_pkg::SET_TWO;
  endproperty
  a_set_legal: assert property (p_set_legal) else $error("bad set"); // R8

  property p_wait_holds;
    (sw_state == scp_pkg::SW_WAIT && !delay_done) |=> $stable(o_active_set);
  endproperty
  a_wait_holds: assert property (p_wait_holds) // R9
    else $error("set switched early");

  property p_gain_now;
    (i_kp_d_calc >= scp_pkg::GAIN_MIN && i_kp_d_calc <= scp_pkg::GAIN_MAX)
      |=> o_kp_d == $past(i_kp_d_calc);
  endproperty
  a_gain_now: assert property (p_gain_now) else $error("gain late"); // R12

  property p_gain_range;
    o_kp_q >= scp_pkg::GAIN_MIN && o_kp_q <= scp_pkg::GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) // R11
    else $error("q gain range");

  property p_kp_d_range;
    o_kp_d >= scp_pkg::GAIN_MIN && o_kp_d <= scp_pkg::GAIN_MAX;
  endproperty
  a_kp_d_range: assert property (p_kp_d_range) // R10
    else $error("d gain range");

  property p_kp_q_now;
    (i_kp_q_calc >= scp_pkg::GAIN_MIN && i_kp_q_calc <= scp_pkg::GAIN_MAX)
      |=> o_kp_q == $past(i_kp_q_calc);
  endproperty
  a_kp_q_now: assert property (p_kp_q_now) else $error("q gain late"); // R12

  property p_unmapped;
    (i_req.valid && !is_mapped(i_req.addr)) |=> o_rsp.err;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");

  // Main scenarios
  c_sum_read: cover property (rd_at(i_req, scp_pkg::ADDR_EVT_SUMMARY));
  c_write: cover property (i_req.valid && i_req.write);
  c_no_delay: cover property (sw_state == scp_pkg::SW_IDLE &&
    target_set != o_active_set && i_set_switch_delay == '0);
  c_switch: cover property (sw_state == scp_pkg::SW_WAIT && delay_done);
  c_retarget: cover property (sw_state == scp_pkg::SW_WAIT &&
                              target_set != pend_set);

endmodule

// *** sim/scp_bus_master.sv ***
// Purpose: Fieldbus master model issuing parameter accesses to the bank
// Assumes: One request at a time, answer within a few cycles
// Notes:   Idle request lines carry inverted junk after each access so stale values never pass; before the first access they are zero
`timescale 1ns/1ps
module scp_bus_master (
  // Clock
  input  wire logic              i_ref_clk,
  // Answer from the bank
  input  wire scp_pkg::scp_rsp_s i_rsp,
  // Request to the bank
  output scp_pkg::scp_req_s      o_req
);
  // Quiet bus at time zero
  initial o_req = '0;

  // One access: a single-cycle request pulse, then a bounded answer wait
  task automatic access(input logic wr, input scp_pkg::scp_word_t addr,
                        input scp_pkg::scp_word_t wdata,
                        output scp_pkg::scp_word_t data, output logic err);
    int n;
    data = 'x;
    err = 1'bx;
    @(posedge i_ref_clk);
    o_req <= '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    @(posedge i_ref_clk);
    o_req <= '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
    for (n = 0; n < 4; n++) begin
      @(posedge i_ref_clk);
      if (i_rsp.valid === 1'b1) begin
        data = i_rsp.data;
        err = i_rsp.err;
        break;
      end
    end
  endtask
endmodule

// *** sim/scp_param_bank_test.sv ***
// Purpose: Self-checking bench for the read-only parameter bank
// Assumes: Delay unit shortened to 4 cycles to keep the run brief
// Notes:   Expected words are worked out here from field positions
`timescale 1ns/1ps
module scp_param_bank_test;
  localparam int unsigned P_UNIT = 4;

  logic                       i_ref_clk = 1'b0;
  logic                       i_rst = 1'b1;
  scp_pkg::scp_req_s          req;
  scp_pkg::scp_rsp_s          rsp;
  logic [scp_pkg::CAP_N-1:0]  cap = '0;
  logic [scp_pkg::EDGE_N-1:0] edges = '0;
  scp_pkg::scp_counts_s       counts = '0;
  scp_pkg::scp_cond_s         cond = '0;
  logic                       set_sel = 1'b0;
  scp_pkg::scp_word_t         sw_delay = '0;
  scp_pkg::scp_word_t         kp_d_calc = 16'h0005;
  scp_pkg::scp_word_t         kp_q_calc = 16'h0005;
  scp_pkg::scp_word_t         act_set;
  scp_pkg::scp_word_t         kp_d;
  scp_pkg::scp_word_t         kp_q;
  scp_pkg::scp_word_t         rd;
  logic                       err;
  int                         miscompares = 0;
  int                         checked = 0;
  scp_pkg::scp_word_t         g_tab[5] = '{16'h0003, 16'h0005, 16'h0064,
                                           16'h319c, 16'h32c8};

  // Clock, 10 ns period
  always #5 i_ref_clk = ~i_ref_clk;

  scp_param_bank #(.P_DELAY_UNIT_CYCLES(P_UNIT)) dut (
    .i_ref_clk          (i_ref_clk),
    .i_rst              (i_rst),
    .i_req              (req),
    .o_rsp              (rsp),
    .i_cap_captured     (cap),
    .i_edge_seen        (edges),
    .i_counts           (counts),
    .i_ready_cond       (cond),
    .i_set_sel          (set_sel),
    .i_set_switch_delay (sw_delay),
    .o_active_set       (act_set),
    .i_kp_d_calc        (kp_d_calc),
    .i_kp_q_calc        (kp_q_calc),
    .o_kp_d             (kp_d),
    .o_kp_q             (kp_q)
  );

  scp_bus_master u_master (
    .i_ref_clk (i_ref_clk),
    .i_rsp     (rsp),
    .o_req     (req)
  );

  // Compare one value and count it
  task automatic check(input string name, input scp_pkg::scp_word_t seen,
                       input scp_pkg::scp_word_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read one parameter and expect a clean answer
  task automatic rd_chk(input scp_pkg::scp_word_t addr,
                        input scp_pkg::scp_word_t exp, input string name);
    u_master.access(1'b0, addr, 16'h0000, rd, err);
    check({name, " err"}, 16'(err), 16'h0000);
    check(name, rd, exp);
  endtask

  // Gains outside the range are held at its ends
  function automatic scp_pkg::scp_word_t clampg(scp_pkg::scp_word_t v);
    if (v < scp_pkg::GAIN_MIN) return scp_pkg::GAIN_MIN;
    if (v > scp_pkg::GAIN_MAX) return scp_pkg::GAIN_MAX;
    return v;
  endfunction

  // Verdict, the single exit of the run
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    rd_chk(scp_pkg::ADDR_ACT_SET, 16'h0001, "set after reset");
    rd_chk(scp_pkg::ADDR_KP_D, scp_pkg::GAIN_MIN, "kp_d reset");
    // Upper count bits set so only low nibbles may show
    counts <= '{in2_fall: 16'hfffe, in2_rise: 16'h0f09,
                in1_fall: 16'habc7, in1_rise: 16'h1235};
    repeat (2) @(posedge i_ref_clk);
    rd_chk(scp_pkg::ADDR_EVT_SUMMARY, 16'he975, "summary");
    // Walking one across all status fields
    for (int n = 0; n < 6; n++) begin
      @(posedge i_ref_clk);
      cap <= 3'((1 << n) & 7);
      edges <= 4'((1 << n) & 15);
      cond <= scp_pkg::scp_cond_s'(6'(1 << n));
      repeat (2) @(posedge i_ref_clk);
      rd_chk(scp_pkg::ADDR_CAP_FLAGS, 16'((1 << n) & 7), "cap");
      rd_chk(scp_pkg::ADDR_EDGE_FLAGS, 16'((1 << n) & 15), "edge");
      rd_chk(scp_pkg::ADDR_READY, 16'(1 << n), "ready");
    end
    // Gains follow at the next edge, clamped
    for (int n = 0; n < 5; n++) begin
      @(posedge i_ref_clk);
      kp_d_calc <= g_tab[n];
      kp_q_calc <= g_tab[(n + 1) % 5];
      @(posedge i_ref_clk);
      #1;
      check("kp_d now", kp_d, clampg(g_tab[n]));
      check("kp_q now", kp_q, clampg(g_tab[(n + 1) % 5]));
      rd_chk(scp_pkg::ADDR_KP_D, clampg(g_tab[n]), "kp_d");
      rd_chk(scp_pkg::ADDR_KP_Q, clampg(g_tab[(n + 1) % 5]), "kp_q");
    end
    // Writes are refused and change nothing
    u_master.access(1'b1, scp_pkg::ADDR_KP_D, 16'h0777, rd, err);
    check("write err", 16'(err), 16'h0001);
    check("write data", rd, 16'h0000);
    u_master.access(1'b1, scp_pkg::ADDR_EVT_SUMMARY, 16'h0000, rd, err);
    check("write err", 16'(err), 16'h0001);
    rd_chk(scp_pkg::ADDR_KP_D, clampg(g_tab[4]), "kp_d kept");
    rd_chk(scp_pkg::ADDR_EVT_SUMMARY, 16'he975, "summary kept");
    u_master.access(1'b0, 16'h0000, 16'h0000, rd, err);
    check("unmapped err", 16'(err), 16'h0001);
    // Switch to set 2 with a delay of two units
    @(posedge i_ref_clk);
    sw_delay <= 16'h0002;
    set_sel <= 1'b1;
    repeat (2 * P_UNIT) @(posedge i_ref_clk);
    #1;
    check("set early", act_set, 16'h0001);
    for (int n = 0; n < 6 && act_set !== scp_pkg::SET_TWO; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
    check("set late", act_set, scp_pkg::SET_TWO);
    rd_chk(scp_pkg::ADDR_ACT_SET, 16'h0002, "set two");
    // Back to set 1 with no delay
    @(posedge i_ref_clk);
    sw_delay <= 16'h0000;
    set_sel <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check("set back", act_set, scp_pkg::SET_ONE);
    // A changed request in mid-wait aborts the switch
    @(posedge i_ref_clk);
    sw_delay <= 16'h0001;
    set_sel <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    set_sel <= 1'b0;
    repeat (3 * P_UNIT) @(posedge i_ref_clk);
    #1;
    check("set aborted", act_set, scp_pkg::SET_ONE);
    test_done();
  end
endmodule
